// file: common/uart_async_pkg.sv
/*
 * Constants and carrier types for the asynchronous character serial channel.
 * Assumes one core clock and a synchronous active-low reset in every user.
 */
`default_nettype none
package uart_async_pkg;
    // --------------------
    // Mode codes and field sizes
    // --------------------
    localparam logic [2:0] MODE_DATA7   = 3'h4;
    localparam logic [2:0] MODE_DATA8   = 3'h5;
    localparam logic [2:0] MODE_DATA9   = 3'h6;
    localparam int         CHAR_W       = 9;
    localparam logic [8:0] MASK_DATA7   = 9'h07f;
    localparam logic [8:0] MASK_DATA8   = 9'h0ff;
    localparam logic [8:0] MASK_DATA9   = 9'h1ff;
    localparam logic [3:0] BITS_DATA7   = 4'h7;
    localparam logic [3:0] BITS_DATA8   = 4'h8;
    localparam logic [3:0] BITS_DATA9   = 4'h9;
    // --------------------
    // Timing counts and FIFO depth
    // --------------------
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;   // 16 sub-ticks per bit
    localparam logic [3:0] START_CENTRE    = 4'h7;   // Start bit re-check point
    localparam logic [4:0] PRESCALE_DIV2   = 5'h01;
    localparam logic [4:0] PRESCALE_DIV8   = 5'h07;
    localparam logic [4:0] PRESCALE_DIV32  = 5'h1f;
    localparam int         FIFO_DEPTH      = 8;
    // --------------------
    // Types
    // --------------------
    typedef enum logic [4:0] {
        SER_IDLE   = 5'h01,
        SER_START  = 5'h02,
        SER_DATA   = 5'h04,
        SER_PARITY = 5'h08,
        SER_STOP   = 5'h10
    } ser_state_e;

    typedef struct packed {
        logic overrun;
        logic framing;
        logic parity;
    } rx_err_s;
endpackage
`default_nettype wire

// file: rtl/uart_async.sv
/*
 * Asynchronous character mode of a serial channel, with its transmit FIFO.
 * Assumes configuration ports held stable while a character is in flight,
 * pins and the external clock asynchronous to i_core_clk (25 MHz).
 */
// Behaviour
// RQ1: one start bit, 7/8/9 data bits
// RQ2: optional odd/even parity after data
// RQ3: one or two stop bits
// RQ4: internal rate prescaled clock over 16(n+1)
// RQ5: external clock pin over 16(n+1)
// RQ6: send needs enable, data, CTS low
// RQ7: receive needs enable and start bit
// RQ8: transmit interrupt on load or completion
// RQ9: receive interrupt on buffer load
// RQ10: overrun near last stop, no load
// RQ11: missing stop bit flags framing error
// RQ12: parity mismatch flags parity error
// RQ13: error summary ORs all errors
// RQ14: mode field 100/101/110 selects length
// RQ15: data in bits 0-6, 0-7, 0-8
// RQ16: MSB-first only for 8-bit characters
// RQ17: data inversion skips start and stop
// RQ18: pin polarity inverts every level
// RQ19: idle output high, or released
// RQ20: flow control CTS, RTS or off
// RQ21: channel split: RTS own, CTS alternate
// RQ22: separate shift register empty flag
// RQ23: centre sampling, start bit re-check
`default_nettype none

// --------------------
// Transmit data FIFO
// --------------------
module uart_async_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic [AW:0]   cnt_d;
    logic          push;
    logic          pop;

    assign push        = i_in_valid & o_in_ready;
    assign pop         = i_out_ready & o_out_valid;
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem[rd_q];
    assign cnt_d       = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage write
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end

    // Pointers, fill level and registered ready
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            wr_q       <= '0;
            rd_q       <= '0;
            cnt_q      <= '0;
            o_in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q      <= cnt_d;
            o_in_ready <= (cnt_d < (AW + 1)'(D));
        end
    end
endmodule

// --------------------
// Channel top
// --------------------
module uart_async
    import uart_async_pkg::*;
(
    input  wire logic         i_core_clk,
    input  wire logic         i_nrst,
    input  wire logic [2:0]   i_serial_mode_field,
    input  wire logic         i_clock_source_select,
    input  wire logic [1:0]   i_divisor_source_select,
    input  wire logic [7:0]   i_bit_rate_divisor,
    input  wire logic         i_stop_bit_count_select,
    input  wire logic         i_parity_enable_bit,
    input  wire logic         i_parity_odd_even_select,
    input  wire logic         i_pin_polarity_invert,
    input  wire logic         i_data_logic_invert,
    input  wire logic         i_bit_order_select,
    input  wire logic         i_open_drain_select,
    input  wire logic         i_flow_control_disable,
    input  wire logic         i_flow_direction_select,
    input  wire logic         i_split_flow_pin_select,
    input  wire logic         i_multi_pin_clock_enable,
    input  wire logic         i_transmit_enable_bit,
    input  wire logic         i_receive_enable_bit,
    input  wire logic         i_tx_interrupt_source_select,
    input  wire logic         i_tx_valid,
    input  wire logic [8:0]   i_tx_data,
    output logic              o_tx_ready,
    input  wire logic         i_rx_read,
    output logic [8:0]        o_receive_buffer,
    output logic              o_receive_complete_flag,
    output logic              o_overrun_flag,
    output logic              o_framing_flag,
    output logic              o_parity_flag,
    output logic              o_error_sum_flag,
    output logic              o_transmit_buffer_empty_flag,
    output logic              o_shift_register_empty_flag,
    output logic              o_tx_irq,
    output logic              o_rx_irq,
    input  wire logic         i_transfer_clock_pin,
    input  wire logic         i_serial_in_pin,
    output logic              o_serial_out_pin,
    output logic              o_serial_out_oe,
    input  wire logic         i_cts_pin,
    input  wire logic         i_alternate_cts_pin,
    output logic              o_rts_pin,
    output logic              o_rts_oe
);
    // --------------------
    // Pin synchronisers
    // --------------------
    logic [1:0] ext_clk_sync_q;
    logic [1:0] rxd_sync_q;
    logic [1:0] cts_sync_q;
    logic [1:0] cts_alt_sync_q;
    logic       ext_clk_prev_q;

    // Two flops on every asynchronous pin
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ext_clk_sync_q <= 2'h0;
            rxd_sync_q     <= 2'h3;
            cts_sync_q     <= 2'h3;
            cts_alt_sync_q <= 2'h3;
            ext_clk_prev_q <= 1'b0;
        end else begin
            ext_clk_sync_q <= {ext_clk_sync_q[0], i_transfer_clock_pin};
            rxd_sync_q     <= {rxd_sync_q[0], i_serial_in_pin};
            cts_sync_q     <= {cts_sync_q[0], i_cts_pin};
            cts_alt_sync_q <= {cts_alt_sync_q[0], i_alternate_cts_pin};
            ext_clk_prev_q <= ext_clk_sync_q[1];
        end
    end

    // --------------------
    // Bit rate generation
    // --------------------
    logic [4:0] pre_cnt_q;
    logic       pre_tick;
    logic       src_tick;
    logic [7:0] brg_q;
    logic       os_tick_q;      // Sixteen-times bit clock enable

    always_comb begin
        unique case (i_divisor_source_select)
            2'h0:    pre_tick = 1'b1;
            2'h1:    pre_tick = ((pre_cnt_q & PRESCALE_DIV2) == PRESCALE_DIV2);
            2'h2:    pre_tick = ((pre_cnt_q & PRESCALE_DIV8) == PRESCALE_DIV8);
            default: pre_tick = (pre_cnt_q == PRESCALE_DIV32);
        endcase
    end

    // External source counts rising edges of the clock pin
    assign src_tick = i_clock_source_select ? (ext_clk_sync_q[1] & ~ext_clk_prev_q) // RQ5
                                            : pre_tick;                              // RQ4

    // Prescaler and divisor: one enable per (n+1) source ticks
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            pre_cnt_q <= 5'h00;
            brg_q     <= 8'h00;
            os_tick_q <= 1'b0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 5'h01;
            os_tick_q <= 1'b0;
            if (src_tick) begin
                if (brg_q == 8'h00) begin
                    brg_q     <= i_bit_rate_divisor; // RQ4
                    os_tick_q <= 1'b1;
                end else begin
                    brg_q <= brg_q - 8'h01;
                end
            end
        end
    end

    // --------------------
    // Character format
    // --------------------
    logic       mode_ok;
    logic [3:0] nbits;
    logic [8:0] dmask;
    logic       msb_first;
    logic       cts_fn;
    logic       cts_level;
    logic       rxd;

    always_comb begin
        mode_ok = 1'b1;
        unique case (i_serial_mode_field) // RQ14
            MODE_DATA7: begin
                nbits = BITS_DATA7;
                dmask = MASK_DATA7; // RQ15
            end
            MODE_DATA8: begin
                nbits = BITS_DATA8;
                dmask = MASK_DATA8;
            end
            MODE_DATA9: begin
                nbits = BITS_DATA9;
                dmask = MASK_DATA9;
            end
            default: begin
                mode_ok = 1'b0;
                nbits   = BITS_DATA8;
                dmask   = MASK_DATA8;
            end
        endcase
    end

    assign msb_first = i_bit_order_select & (i_serial_mode_field == MODE_DATA8); // RQ16
    assign cts_fn    = ~i_flow_control_disable & ~i_flow_direction_select;       // RQ20
    assign cts_level = (i_split_flow_pin_select & ~i_multi_pin_clock_enable)     // RQ21
                       ? cts_alt_sync_q[1] : cts_sync_q[1];
    assign rxd       = rxd_sync_q[1] ^ i_pin_polarity_invert;                    // RQ18

    // Bit position for the current data bit
    function automatic logic [3:0] bit_pos(input logic [3:0] cnt, input logic msb, input logic [3:0] n);
        bit_pos = msb ? (n - 4'h1 - cnt) : cnt;
    endfunction

    // --------------------
    // Transmitter
    // --------------------
    ser_state_e tx_state_q;
    logic [3:0] tx_sub_q;
    logic [3:0] tx_cnt_q;
    logic [8:0] tx_sh_q;
    logic       tx_par_q;
    logic       tx_stop2_q;
    logic       tx_level;
    logic       fifo_valid;
    logic [8:0] fifo_data;
    logic       fifo_pop;

    uart_async_fifo #(
        .W (CHAR_W),
        .D (FIFO_DEPTH)
    ) u_tx_fifo (
        .i_core_clk  (i_core_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (i_tx_valid),
        .o_in_ready  (o_tx_ready),
        .i_in_data   (i_tx_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_data)
    );

    // Start condition: enabled, data buffered, CTS low when selected
    assign fifo_pop = os_tick_q & mode_ok & (tx_state_q == SER_IDLE) & i_transmit_enable_bit
                      & fifo_valid & ~(cts_fn & cts_level); // RQ6

    // Transmit sequencer
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            tx_state_q <= SER_IDLE;
            tx_sub_q   <= 4'h0;
            tx_cnt_q   <= 4'h0;
            tx_sh_q    <= 9'h000;
            tx_par_q   <= 1'b0;
            tx_stop2_q <= 1'b0;
            o_tx_irq   <= 1'b0;
        end else begin
            o_tx_irq <= 1'b0;
            if (!mode_ok) begin
                tx_state_q <= SER_IDLE;
            end else if (fifo_pop) begin
                tx_sh_q    <= (fifo_data ^ {9{i_data_logic_invert}}) & dmask; // RQ17
                tx_par_q   <= ^((fifo_data ^ {9{i_data_logic_invert}}) & dmask)
                              ^ i_parity_odd_even_select; // RQ2
                tx_stop2_q <= i_stop_bit_count_select;
                tx_state_q <= SER_START; // RQ1
                tx_sub_q   <= 4'h0;
                tx_cnt_q   <= 4'h0;
                o_tx_irq   <= ~i_tx_interrupt_source_select; // RQ8
            end else if (os_tick_q && tx_state_q != SER_IDLE) begin
                tx_sub_q <= tx_sub_q + 4'h1;
                if (tx_sub_q == OVERSAMPLE_LAST) begin
                    unique case (tx_state_q)
                        SER_START: tx_state_q <= SER_DATA;
                        SER_DATA: begin
                            tx_cnt_q <= tx_cnt_q + 4'h1;
                            if (tx_cnt_q == nbits - 4'h1) begin
                                tx_state_q <= i_parity_enable_bit ? SER_PARITY : SER_STOP;
                            end
                        end
                        SER_PARITY: tx_state_q <= SER_STOP;
                        SER_STOP: begin
                            if (tx_stop2_q) begin
                                tx_stop2_q <= 1'b0; // RQ3
                            end else begin
                                tx_state_q <= SER_IDLE;
                                o_tx_irq   <= i_tx_interrupt_source_select; // RQ8
                            end
                        end
                        default: tx_state_q <= SER_IDLE;
                    endcase
                end
            end
        end
    end

    always_comb begin
        unique case (tx_state_q)
            SER_START:  tx_level = 1'b0;
            SER_DATA:   tx_level = tx_sh_q[bit_pos(tx_cnt_q, msb_first, nbits)];
            SER_PARITY: tx_level = ~tx_par_q; // Select low flips the even sum; select high sends the even sum
            default:    tx_level = 1'b1;
        endcase
    end

    // Pin drive; open drain only pulls low
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_serial_out_pin             <= 1'b1;
            o_serial_out_oe              <= 1'b0;
            o_transmit_buffer_empty_flag <= 1'b1;
            o_shift_register_empty_flag  <= 1'b1;
        end else begin
            o_serial_out_pin             <= tx_level ^ i_pin_polarity_invert; // RQ18
            o_serial_out_oe              <= mode_ok &
                (~i_open_drain_select | ~(tx_level ^ i_pin_polarity_invert)); // RQ19
            o_transmit_buffer_empty_flag <= ~fifo_valid;
            o_shift_register_empty_flag  <= (tx_state_q == SER_IDLE); // RQ22
        end
    end

    // --------------------
    // Receiver
    // --------------------
    ser_state_e rx_state_q;
    logic [3:0] rx_sub_q;
    logic [3:0] rx_cnt_q;
    logic [8:0] rx_sh_q;
    logic       rx_par_q;
    logic       rx_stop2_q;
    logic       rx_fe_q;
    logic       rx_ovr_q;
    logic       rx_load_q;
    logic       rx_err_pulse_q;
    rx_err_s    rx_err_q;
    logic       rx_sample;

    assign rx_sample = os_tick_q & (rx_sub_q == OVERSAMPLE_LAST);

    // Receive sequencer, samples at bit centre
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            rx_state_q     <= SER_IDLE;
            rx_sub_q       <= 4'h0;
            rx_cnt_q       <= 4'h0;
            rx_sh_q        <= 9'h000;
            rx_par_q       <= 1'b0;
            rx_stop2_q     <= 1'b0;
            rx_fe_q        <= 1'b0;
            rx_ovr_q       <= 1'b0;
            rx_load_q      <= 1'b0;
            rx_err_pulse_q <= 1'b0;
            rx_err_q       <= '0;
        end else begin
            rx_load_q      <= 1'b0;
            rx_err_pulse_q <= 1'b0;
            if (!mode_ok || !i_receive_enable_bit) begin
                rx_state_q <= SER_IDLE;
            end else if (os_tick_q) begin
                rx_sub_q <= rx_sub_q + 4'h1;
                unique case (rx_state_q)
                    SER_IDLE: begin
                        if (!rxd) begin
                            rx_state_q <= SER_START; // RQ7
                            rx_sub_q   <= 4'h0;
                        end
                    end
                    SER_START: begin
                        if (rx_sub_q == START_CENTRE) begin
                            rx_sub_q   <= 4'h0;
                            rx_cnt_q   <= 4'h0;
                            rx_sh_q    <= 9'h000;
                            rx_par_q   <= i_parity_odd_even_select;
                            rx_stop2_q <= i_stop_bit_count_select;
                            rx_fe_q    <= 1'b0;
                            rx_ovr_q   <= 1'b0;
                            rx_state_q <= rxd ? SER_IDLE : SER_DATA; // RQ23
                        end
                    end
                    SER_DATA: begin
                        if (rx_sample) begin
                            rx_sh_q[bit_pos(rx_cnt_q, msb_first, nbits)] <= rxd; // RQ16
                            rx_par_q <= rx_par_q ^ rxd;
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q == nbits - 4'h1) begin
                                rx_state_q <= i_parity_enable_bit ? SER_PARITY : SER_STOP;
                                if (!i_parity_enable_bit && !rx_stop2_q) begin
                                    rx_ovr_q <= o_receive_complete_flag; // RQ10
                                end
                            end
                        end
                    end
                    SER_PARITY: begin
                        if (rx_sample) begin
                            rx_par_q   <= rx_par_q ^ rxd ^ 1'b1; // RQ12
                            rx_state_q <= SER_STOP;
                            if (!rx_stop2_q) begin
                                rx_ovr_q <= o_receive_complete_flag; // RQ10
                            end
                        end
                    end
                    SER_STOP: begin
                        if (rx_sample) begin
                            rx_fe_q <= rx_fe_q | ~rxd; // RQ11
                            if (rx_stop2_q) begin
                                rx_stop2_q <= 1'b0;
                                rx_ovr_q   <= o_receive_complete_flag; // RQ10
                            end else begin
                                rx_state_q      <= SER_IDLE;
                                rx_load_q       <= ~rx_ovr_q; // RQ10
                                rx_err_pulse_q  <= 1'b1;
                                rx_err_q.overrun <= rx_ovr_q;
                                rx_err_q.framing <= rx_fe_q | ~rxd;
                                rx_err_q.parity  <= i_parity_enable_bit & rx_par_q;
                            end
                        end
                    end
                    default: rx_state_q <= SER_IDLE;
                endcase
            end
        end
    end

    // Receive buffer, completion flag and interrupt
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_receive_buffer        <= 9'h000;
            o_receive_complete_flag <= 1'b0;
            o_rx_irq                <= 1'b0;
        end else begin
            o_rx_irq <= rx_load_q; // RQ9
            if (rx_load_q) begin
                o_receive_buffer        <= (rx_sh_q ^ {9{i_data_logic_invert}}) & dmask; // RQ17
                o_receive_complete_flag <= 1'b1; // Set beats read clear
            end else if (i_rx_read) begin
                o_receive_complete_flag <= 1'b0;
            end
        end
    end

    // Error flags: set at character end, cleared by a buffer read
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_overrun_flag   <= 1'b0;
            o_framing_flag   <= 1'b0;
            o_parity_flag    <= 1'b0;
            o_error_sum_flag <= 1'b0;
        end else begin
            o_overrun_flag   <= (rx_err_pulse_q & rx_err_q.overrun) | (o_overrun_flag & ~i_rx_read);
            o_framing_flag   <= (rx_err_pulse_q & rx_err_q.framing) | (o_framing_flag & ~i_rx_read);
            o_parity_flag    <= (rx_err_pulse_q & rx_err_q.parity) | (o_parity_flag & ~i_rx_read);
            o_error_sum_flag <= (rx_err_pulse_q & (|rx_err_q)) | (o_error_sum_flag & ~i_rx_read); // RQ13
        end
    end

    // --------------------
    // Request-to-send output
    // --------------------
    // Low while ready to take a character; released when flow is off
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_rts_pin <= 1'b1;
            o_rts_oe  <= 1'b0;
        end else begin
            o_rts_pin <= ~(i_receive_enable_bit & ~o_receive_complete_flag);
            o_rts_oe  <= ~i_flow_control_disable & i_flow_direction_select; // RQ20
        end
    end
endmodule
`default_nettype wire

// file: tb/uart_async_sva.sv
/* Checker on the channel top ports. Assumes binding into uart_async. */
`default_nettype none
module uart_async_chk (
    input wire logic i_core_clk, i_nrst, i_pin_polarity_invert, i_open_drain_select,
    input wire logic i_transmit_enable_bit, i_tx_interrupt_source_select, o_rx_irq,
    input wire logic o_receive_complete_flag, o_overrun_flag, o_error_sum_flag,
    input wire logic o_shift_register_empty_flag, o_serial_out_pin, o_serial_out_oe, o_tx_irq
);
    // Shared clock and reset for all checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    property p_rxi; o_rx_irq |-> o_receive_complete_flag; endproperty
    a_rxi: assert property (p_rxi) else $error("rx irq without flag");
    property p_ovr; $rose(o_overrun_flag) |-> !o_rx_irq; endproperty
    a_ovr: assert property (p_ovr) else $error("irq on overrun");
    property p_sum; $rose(o_overrun_flag) |-> o_error_sum_flag; endproperty
    a_sum: assert property (p_sum) else $error("no error sum");
    property p_stb; $fell(o_shift_register_empty_flag)
        |-> o_serial_out_pin == $past(i_pin_polarity_invert); endproperty
    a_stb: assert property (p_stb) else $error("bad start level");
    property p_ten; $fell(o_shift_register_empty_flag) |-> $past(i_transmit_enable_bit); endproperty
    a_ten: assert property (p_ten) else $error("sent while disabled");
    property p_idl; o_shift_register_empty_flag && o_serial_out_oe && !$past(i_open_drain_select)
        |-> o_serial_out_pin == !$past(i_pin_polarity_invert); endproperty
    a_idl: assert property (p_idl) else $error("bad idle level");
    property p_odr; $past(i_open_drain_select) && o_serial_out_oe |-> !o_serial_out_pin; endproperty
    a_odr: assert property (p_odr) else $error("open drain drives high");
    property p_tx0; o_tx_irq && !$past(i_tx_interrupt_source_select)
        |=> $fell(o_shift_register_empty_flag); endproperty
    a_tx0: assert property (p_tx0) else $error("tx irq not at load");
    c_rx: cover property (o_rx_irq);
    c_ov: cover property ($rose(o_overrun_flag));
    c_t1: cover property (o_tx_irq && i_tx_interrupt_source_select);
endmodule
`default_nettype wire

// file: tb/uart_far_end.sv
/* Far serial device echoing each level back. Assumes a pull-up on the line. */
`default_nettype none
module uart_far_end (
    input  wire logic i_txd,
    input  wire logic i_txd_oe,
    output logic      o_rxd
);
    // Echo of the frame as sent, pull-up while released
    assign o_rxd = i_txd_oe ? i_txd : 1'h1;
endmodule
`default_nettype wire

// file: tb/async_serial_uart_mode_tb.sv
/* Loopback bench of the channel. Assumes uart_async, its package and checker. */
`default_nettype none
module async_serial_uart_mode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_async_pkg::*;
    logic i_core_clk = 1'h0, i_nrst = 1'h0, i_tx_valid = 1'h0, i_rx_read = 1'h0, i_cts_pin = 1'h0;
    logic i_transfer_clock_pin = 1'h0, i_transmit_enable_bit = 1'h1, i_receive_enable_bit = 1'h1;
    logic i_pin_polarity_invert = 1'h0, i_split_flow_pin_select = 1'h0, i_multi_pin_clock_enable = 1'h0;
    logic i_alternate_cts_pin = 1'h1, i_tx_interrupt_source_select = 1'h0, i_clock_source_select;
    logic i_stop_bit_count_select, i_parity_enable_bit, i_parity_odd_even_select, i_data_logic_invert;
    logic i_bit_order_select, i_open_drain_select, i_flow_control_disable, i_flow_direction_select;
    logic o_tx_ready, o_receive_complete_flag, o_overrun_flag, o_framing_flag, o_parity_flag, o_tx_irq;
    logic o_error_sum_flag, o_transmit_buffer_empty_flag, o_shift_register_empty_flag, o_rx_irq;
    logic o_serial_out_pin, o_serial_out_oe, o_rts_pin, o_rts_oe;
    logic [2:0] i_serial_mode_field = MODE_DATA8;
    logic [1:0] i_divisor_source_select;
    logic [7:0] i_bit_rate_divisor;
    logic [8:0] i_tx_data = 9'h000, o_receive_buffer, m;
    logic [31:0] s = 32'h33;
    logic [8:0] q[$];
    wire i_serial_in_pin;
    int err_count = 0, num_checks = 0;
    uart_async uut (.*);
    uart_far_end far (.i_txd(o_serial_out_pin), .i_txd_oe(o_serial_out_oe), .o_rxd(i_serial_in_pin));
    // Core clock and an unrelated external transfer clock
    always #20 i_core_clk = ~i_core_clk;
    always #30 i_transfer_clock_pin = ~i_transfer_clock_pin;
    task tick; @(posedge i_core_clk); #1; endtask
    task chk(input logic [8:0] a, input logic [8:0] e);
        num_checks++;
        if (a !== e) begin
            err_count++;
            $display("mismatch %0t %h %h", $time, a, e);
        end
    endtask
    task cfg(input logic [31:0] r);
        {i_stop_bit_count_select, i_parity_enable_bit, i_parity_odd_even_select, i_data_logic_invert,
         i_bit_order_select, i_open_drain_select, i_clock_source_select, i_flow_control_disable,
         i_flow_direction_select} = r[8:0];
        i_divisor_source_select = {1'h0, r[9]};
        i_bit_rate_divisor = {7'h00, r[10]};
        i_pin_polarity_invert = r[11];
    endtask
    task send(input logic [8:0] d);
        repeat (9) if (o_tx_ready !== 1'h1) tick;
        i_tx_data = d;
        i_tx_valid = 1'h1;
        q.push_back(d & m);
        tick;
        i_tx_valid = 1'h0;
        tick;
    endtask
    task wrx; repeat (30000) if (o_rx_irq !== 1'h1) tick; chk(9'(o_rx_irq), 9'h001); endtask
    task rd; i_rx_read = 1'h1; tick; i_rx_read = 1'h0; endtask
    // Xorshift source of the random stimulus
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    task report_and_stop;
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Random frames over modes, then FIFO full under CTS, then overrun
    initial begin
        cfg(32'h0);
        repeat (8) @(posedge i_core_clk);
        #1 i_nrst = 1'h1;
        tick;
        for (int k = 0; k < 24; k++) begin
            repeat (3000) if (o_shift_register_empty_flag !== 1'h1) tick;
            s = xs(s);
            i_serial_mode_field = MODE_DATA7 + 3'(k % 3);
            m = MASK_DATA9 >> (2 - k % 3);
            cfg(s);
            i_bit_order_select &= (k % 3 == 1);
            i_tx_interrupt_source_select = s[30];
            repeat (64) tick;
            send(s[24:16]);
            wrx;
            chk(o_receive_buffer, q.pop_front());
            chk(9'({o_framing_flag, o_parity_flag, o_overrun_flag}), 9'h000);
            rd;
        end
        cfg(32'h0);
        i_cts_pin = 1'h1;
        repeat (3) tick;
        for (int k = 0; k < 8; k++) send(9'(k * 37));
        tick;
        chk(9'({o_tx_ready, o_shift_register_empty_flag, o_transmit_buffer_empty_flag}), 9'h002);
        i_cts_pin = 1'h0;
        repeat (8) begin
            wrx;
            chk(o_receive_buffer, q.pop_front());
            rd;
        end
        i_flow_direction_select = 1'h1;
        send(9'h0a5);
        send(9'h05a);
        wrx;
        chk(o_receive_buffer, q.pop_front());
        repeat (3000) if (o_overrun_flag !== 1'h1) tick;
        chk(9'({o_overrun_flag, o_error_sum_flag, o_receive_complete_flag}), 9'h007);
        chk(9'({o_rts_pin, o_rts_oe}), 9'h003);
        rd;
        tick;
        chk(9'({o_overrun_flag, o_rts_pin}), 9'h000);
        report_and_stop;
    end
    // Watchdog against a hang
    initial begin
        #4000000;
        err_count++;
        report_and_stop;
    end
endmodule
bind uart_async uart_async_chk chk (.*);
`default_nettype wire
